//--- common/tlr_pkg.sv
package tlr_pkg;
	// I/O ports: counters 0..2, then the command port
	localparam logic [7:0] PORT_CNT0 = 8'h40;
	localparam logic [7:0] PORT_CNT2 = 8'h42;
	localparam logic [7:0] PORT_CMD  = 8'h43;
	localparam int         NCNT      = 3;

	// Command byte field positions
	localparam int SEL_HI  = 7;
	localparam int SEL_LO  = 6;
	localparam int RW_HI   = 5;
	localparam int RW_LO   = 4;
	localparam int MODE_HI = 3;
	localparam int MODE_LO = 1;
	localparam int BCD_BIT = 0;
	localparam int RB_CNT  = 5;
	localparam int RB_ST   = 4;

	// Status byte field positions
	localparam int ST_OUT  = 7;
	localparam int ST_NULL = 6;

	// Field encodings
	localparam logic [1:0] SEL_RB   = 2'h3;
	localparam logic [1:0] RW_LATCH = 2'h0;
	localparam logic [1:0] RW_LSB   = 2'h1;
	localparam logic [1:0] RW_MSB   = 2'h2;
	localparam logic [1:0] RW_BOTH  = 2'h3;

	// Values after reset
	localparam logic [5:0]  CFG_RST  = 6'h00;
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam logic        NULL_RST = 1'b1;

	// Byte pointer for two-byte transfers
	typedef enum logic {
		TLR_BYTE_LO = 1'b0,
		TLR_BYTE_HI = 1'b1
	} tlr_byte_e;
endpackage

//--- core/tlr_core.sv
// Overview of operation
// - New count accepted without new control.
// - Latch command snapshots the counting element.
// - Snapshot held until read or reprogram.
// - Each counter keeps its own snapshot.
// - Repeated latch before read is ignored.
// - Latch decode: select 7-6, 5-4 zero.
// - Select code 11 means read-back command.
// - Read-back bit 5 low captures count.
// - Read-back bit 4 low captures status.
// - Read-back bits 3-1 mask counters.
// - Status returned first when both captured.
// - Captured count follows status, one/two reads.
// - Repeated read-back before read ignored.
// - Captured items frozen until read/reprogram.
// - Status bit 7 shows output level.
// - Null flag set on write, cleared on load.
// - Status bits 5-0 show programmed setup.
// - Byte size 01 lo, 10 hi, 11 both.
// - Command port 043H, counters 040H-042H.
`timescale 1ns/1ps
`default_nettype none
module tlr_core (
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               rstn,
	// Byte-wide host I/O
	input  wire logic [7:0]         io_addr,
	input  wire logic               io_wr,
	input  wire logic               io_rd,
	input  wire logic [7:0]         io_wdata,
	output logic      [7:0]         io_rdata,
	// Counting element side
	input  wire logic [2:0][15:0]   ce_value,
	input  wire logic [2:0]         out_level,
	input  wire logic [2:0]         ce_loaded,
	// Programmed setup to the counters
	output logic      [2:0][15:0]   init_count,
	output logic      [2:0]         count_written,
	output logic      [2:0]         ctrl_written,
	output logic      [2:0][1:0]    byte_access_size,
	output logic      [2:0][2:0]    operating_mode_field,
	output logic      [2:0]         bcd_select
);

	// Command decode
	logic       cmd_wr;
	logic [1:0] counter_select_code;
	logic       is_rb;
	logic       capture_count_n;
	logic       capture_status_n;
	logic [2:0] counter_select_mask;
	logic [2:0] port_wr;
	logic [2:0] port_rd;

	// Per-counter state
	logic [5:0]        cfg_q [3];
	logic [5:0]        cfg_d [3];
	logic              prog_q [3];
	logic              prog_d [3];
	logic              null_q [3];
	logic              null_d [3];
	logic [15:0]       init_q [3];
	logic [15:0]       init_d [3];
	logic              cnt_lat_q [3];
	logic              cnt_lat_d [3];
	logic [15:0]       cnt_snap_q [3];
	logic [15:0]       cnt_snap_d [3];
	logic              st_lat_q [3];
	logic              st_lat_d [3];
	logic [7:0]        st_snap_q [3];
	logic [7:0]        st_snap_d [3];
	tlr_pkg::tlr_byte_e wr_ptr_q [3];
	tlr_pkg::tlr_byte_e wr_ptr_d [3];
	tlr_pkg::tlr_byte_e rd_ptr_q [3];
	tlr_pkg::tlr_byte_e rd_ptr_d [3];
	logic [2:0]        cw_q;
	logic [2:0]        cw_d;
	logic [2:0]        ctw_q;
	logic [2:0]        ctw_d;
	logic [7:0]        rdata_q;
	logic [7:0]        rdata_d;

	assign cmd_wr = io_wr && (io_addr == tlr_pkg::PORT_CMD);
	assign counter_select_code = io_wdata[tlr_pkg::SEL_HI:tlr_pkg::SEL_LO];
	assign is_rb = (counter_select_code == tlr_pkg::SEL_RB);
	assign capture_count_n = io_wdata[tlr_pkg::RB_CNT];
	assign capture_status_n = io_wdata[tlr_pkg::RB_ST];
	assign counter_select_mask = io_wdata[tlr_pkg::MODE_HI:tlr_pkg::MODE_LO];

	// Counter port strobes
	always_comb begin
		for (int i = 0; i < tlr_pkg::NCNT; i++) begin
			port_wr[i] = io_wr && (io_addr == tlr_pkg::PORT_CNT0 + 8'(i));
			port_rd[i] = io_rd && (io_addr == tlr_pkg::PORT_CNT0 + 8'(i));
		end
	end

	// Next state of every counter
	always_comb begin
		logic       sel;
		logic [1:0] rw;
		logic [15:0] v;
		sel = 1'b0;
		rw = tlr_pkg::RW_LATCH;
		v = tlr_pkg::CNT_RST;
		rdata_d = rdata_q;
		for (int i = 0; i < tlr_pkg::NCNT; i++) begin
			cfg_d[i] = cfg_q[i];
			prog_d[i] = prog_q[i];
			null_d[i] = null_q[i];
			init_d[i] = init_q[i];
			cnt_lat_d[i] = cnt_lat_q[i];
			cnt_snap_d[i] = cnt_snap_q[i];
			st_lat_d[i] = st_lat_q[i];
			st_snap_d[i] = st_snap_q[i];
			wr_ptr_d[i] = wr_ptr_q[i];
			rd_ptr_d[i] = rd_ptr_q[i];
			cw_d[i] = 1'b0;
			ctw_d[i] = 1'b0;
			rw = cfg_q[i][5:4];
			sel = (counter_select_code == 2'(i));
			if (ce_loaded[i]) begin
				null_d[i] = 1'b0;
			end
			if (cmd_wr && !is_rb && sel) begin
				// latch command when size field is 00
				if (io_wdata[tlr_pkg::RW_HI:tlr_pkg::RW_LO] == tlr_pkg::RW_LATCH) begin
					if (!cnt_lat_q[i]) begin
						cnt_lat_d[i] = 1'b1;
						cnt_snap_d[i] = ce_value[i];
					end
				end else begin
					cfg_d[i] = io_wdata[5:0];
					prog_d[i] = 1'b1;
					null_d[i] = 1'b1;
					cnt_lat_d[i] = 1'b0;
					st_lat_d[i] = 1'b0;
					wr_ptr_d[i] = tlr_pkg::TLR_BYTE_LO;
					rd_ptr_d[i] = tlr_pkg::TLR_BYTE_LO;
					cw_d[i] = 1'b1;
				end
			end
			if (cmd_wr && is_rb && counter_select_mask[i]) begin
				if (!capture_count_n && !cnt_lat_q[i]) begin
					cnt_lat_d[i] = 1'b1;
					cnt_snap_d[i] = ce_value[i];
				end
				if (!capture_status_n && !st_lat_q[i]) begin
					st_lat_d[i] = 1'b1;
					st_snap_d[i] = {out_level[i], null_q[i], cfg_q[i]};
				end
			end
			if (port_wr[i] && prog_q[i]) begin
				null_d[i] = 1'b1;
				unique case (rw)
					tlr_pkg::RW_LSB: begin
						init_d[i][7:0] = io_wdata;
						ctw_d[i] = 1'b1;
					end
					tlr_pkg::RW_MSB: begin
						init_d[i][15:8] = io_wdata;
						ctw_d[i] = 1'b1;
					end
					tlr_pkg::RW_BOTH: begin
						if (wr_ptr_q[i] == tlr_pkg::TLR_BYTE_LO) begin
							init_d[i][7:0] = io_wdata;
							wr_ptr_d[i] = tlr_pkg::TLR_BYTE_HI;
						end else begin
							init_d[i][15:8] = io_wdata;
							wr_ptr_d[i] = tlr_pkg::TLR_BYTE_LO;
							ctw_d[i] = 1'b1;
						end
					end
					default: begin
						null_d[i] = null_q[i];
					end
				endcase
			end
			// Counter port read
			if (port_rd[i]) begin
				if (st_lat_q[i]) begin
					rdata_d = st_snap_q[i];
					st_lat_d[i] = 1'b0;
				end else begin
					v = cnt_lat_q[i] ? cnt_snap_q[i] : ce_value[i];
					// Release only a held latch, a new capture wins
					unique case (rw)
						tlr_pkg::RW_MSB: begin
							rdata_d = v[15:8];
							cnt_lat_d[i] = cnt_lat_d[i] && !cnt_lat_q[i];
						end
						tlr_pkg::RW_BOTH: begin
							if (rd_ptr_q[i] == tlr_pkg::TLR_BYTE_LO) begin
								rdata_d = v[7:0];
								rd_ptr_d[i] = tlr_pkg::TLR_BYTE_HI;
							end else begin
								rdata_d = v[15:8];
								rd_ptr_d[i] = tlr_pkg::TLR_BYTE_LO;
								cnt_lat_d[i] = cnt_lat_d[i] && !cnt_lat_q[i];
							end
						end
						default: begin
							rdata_d = v[7:0];
							cnt_lat_d[i] = cnt_lat_d[i] && !cnt_lat_q[i];
						end
					endcase
				end
			end
		end
	end

	// State registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < tlr_pkg::NCNT; i++) begin
				cfg_q[i] <= tlr_pkg::CFG_RST;
				prog_q[i] <= 1'b0;
				null_q[i] <= tlr_pkg::NULL_RST;
				init_q[i] <= tlr_pkg::CNT_RST;
				cnt_lat_q[i] <= 1'b0;
				cnt_snap_q[i] <= tlr_pkg::CNT_RST;
				st_lat_q[i] <= 1'b0;
				st_snap_q[i] <= tlr_pkg::BYTE_RST;
				wr_ptr_q[i] <= tlr_pkg::TLR_BYTE_LO;
				rd_ptr_q[i] <= tlr_pkg::TLR_BYTE_LO;
			end
			cw_q <= 3'h0;
			ctw_q <= 3'h0;
			rdata_q <= tlr_pkg::BYTE_RST;
		end else begin
			for (int i = 0; i < tlr_pkg::NCNT; i++) begin
				cfg_q[i] <= cfg_d[i];
				prog_q[i] <= prog_d[i];
				null_q[i] <= null_d[i];
				init_q[i] <= init_d[i];
				cnt_lat_q[i] <= cnt_lat_d[i];
				cnt_snap_q[i] <= cnt_snap_d[i];
				st_lat_q[i] <= st_lat_d[i];
				st_snap_q[i] <= st_snap_d[i];
				wr_ptr_q[i] <= wr_ptr_d[i];
				rd_ptr_q[i] <= rd_ptr_d[i];
			end
			cw_q <= cw_d;
			ctw_q <= ctw_d;
			rdata_q <= rdata_d;
		end
	end

	// Outputs from flip-flops
	always_comb begin
		for (int i = 0; i < tlr_pkg::NCNT; i++) begin
			init_count[i] = init_q[i];
			byte_access_size[i] = cfg_q[i][5:4];
			operating_mode_field[i] = cfg_q[i][3:1];
			bcd_select[i] = cfg_q[i][0];
		end
	end
	assign io_rdata = rdata_q;
	assign count_written = ctw_q;
	assign ctrl_written = cw_q;

	// Helper strobes for checks on counter 0
	logic ctl0;
	logic lat0;
	assign ctl0 = cmd_wr && !is_rb && (counter_select_code == 2'h0) && (io_wdata[5:4] != 2'h0);
	assign lat0 = cmd_wr && !is_rb && (counter_select_code == 2'h0) && (io_wdata[5:4] == 2'h0);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	latch_copy_a: assert property (lat0 && !cnt_lat_q[0] |=> cnt_lat_q[0] && cnt_snap_q[0] == $past(ce_value[0]))
		else $error("latch did not copy counting element");
	latch_hold_a: assert property (cnt_lat_q[0] && !port_rd[0] && !ctl0 |=> $stable(cnt_snap_q[0]) && cnt_lat_q[0])
		else $error("latched count changed before read");
	latch_release_a: assert property (cnt_lat_q[0] && !st_lat_q[0] && port_rd[0] && cfg_q[0][5:4] == 2'h1 && !lat0
		|=> !cnt_lat_q[0])
		else $error("latch not released after read");
	status_first_a: assert property (st_lat_q[0] && port_rd[0] |=> io_rdata == $past(st_snap_q[0]))
		else $error("status byte not returned first");
	status_capture_a: assert property (cmd_wr && is_rb && !io_wdata[4] && io_wdata[1] && !st_lat_q[0]
		|=> st_snap_q[0] == {$past(out_level[0]), $past(null_q[0]), $past(cfg_q[0])})
		else $error("status snapshot wrong");
	null_set_a: assert property (ctl0 || (port_wr[0] && prog_q[0]) |=> null_q[0])
		else $error("null flag not set by write");
	null_clear_a: assert property (ce_loaded[0] && !ctl0 && !port_wr[0] |=> !null_q[0])
		else $error("null flag not cleared by load");
	live_read_a: assert property (!cnt_lat_q[0] && !st_lat_q[0] && port_rd[0] && cfg_q[0][5:4] == 2'h1
		|=> io_rdata == $past(ce_value[0][7:0]))
		else $error("live read returned wrong byte");
	count_write_a: assert property (port_wr[0] && prog_q[0] && cfg_q[0][5:4] == 2'h1
		|=> count_written[0] && init_count[0][7:0] == $past(io_wdata))
		else $error("count write not accepted");
	two_byte_a: assert property (port_wr[0] && prog_q[0] && cfg_q[0][5:4] == 2'h3 && wr_ptr_q[0] == tlr_pkg::TLR_BYTE_LO
		|=> !count_written[0] && wr_ptr_q[0] == tlr_pkg::TLR_BYTE_HI)
		else $error("low byte of two-byte count mishandled");

endmodule
`default_nettype wire

//--- test/tlr_host.sv
`timescale 1ns/1ps
`default_nettype none
module tlr_host (
	// Clock
	input  wire logic       mclk,
	// Byte-wide host I/O
	output logic      [7:0] io_addr,
	output logic            io_wr,
	output logic            io_rd,
	output logic      [7:0] io_wdata,
	input  wire logic [7:0] io_rdata
);
	// Idle bus at time zero
	initial begin
		io_addr = 8'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end

	// One byte write, released data inverted
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge mclk);
		io_wr <= 1'b0;
		io_wdata <= ~d;
	endtask

	// One byte read, data taken one edge after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge mclk);
		io_rd <= 1'b0;
		@(posedge mclk);
		d = io_rdata;
	endtask
endmodule
`default_nettype wire

//--- test/timer_latch_readback_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module timer_latch_readback_control_bench;
	logic             mclk;
	logic             rstn;
	logic [7:0]       io_addr;
	logic             io_wr;
	logic             io_rd;
	logic [7:0]       io_wdata;
	logic [7:0]       io_rdata;
	logic [2:0][15:0] ce_value;
	logic [2:0]       out_level;
	logic [2:0]       ce_loaded;
	logic [2:0][15:0] init_count;
	logic [2:0][1:0]  byte_access_size;
	logic [2:0][2:0]  operating_mode_field;
	logic [2:0]       bcd_select;
	logic [2:0]       count_written;
	logic [2:0]       ctrl_written;
	logic [7:0]       b;
	int               error_cnt;
	int               n_tests;
	int               cyc;
	int               cw_n;
	int               ctw_n;

	tlr_core tlr_core_inst (.mclk(mclk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .ce_value(ce_value), .out_level(out_level),
		.ce_loaded(ce_loaded), .init_count(init_count), .count_written(count_written), .ctrl_written(ctrl_written),
		.byte_access_size(byte_access_size), .operating_mode_field(operating_mode_field),
		.bcd_select(bcd_select));
	tlr_host tlr_host_inst (.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata));

	// Clock, 20 ns period
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic results();
		$display("checks=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Read one byte of a counter port and compare
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		tlr_host_inst.rd(a, b);
		chk({8'h00, b}, {8'h00, exp});
	endtask

	// Read one byte of counter 0 and compare
	task automatic rd0(input logic [7:0] exp);
		rdc(8'h40, exp);
	endtask

	// Control word, then counts without a new control word
	task automatic t_program();
		tlr_host_inst.wr(8'h43, 8'h34);
		@(posedge mclk);
		chk(16'(byte_access_size[0]), 16'h3);
		chk(16'(operating_mode_field[0]), 16'h2);
		chk(16'(bcd_select[0]), 16'h0);
		tlr_host_inst.wr(8'h40, 8'h34);
		tlr_host_inst.wr(8'h40, 8'h12);
		@(posedge mclk);
		chk(init_count[0], 16'h1234);
		tlr_host_inst.wr(8'h40, 8'h78);
		tlr_host_inst.wr(8'h40, 8'h56);
		@(posedge mclk);
		chk(init_count[0], 16'h5678);
		@(posedge mclk);
		chk(16'(cw_n), 16'h0001);
		chk(16'(ctw_n), 16'h0002);
	endtask

	// Live reads, latch, repeated latch, release
	task automatic t_latch();
		ce_value[0] <= 16'habcd;
		rd0(8'hcd);
		rd0(8'hab);
		tlr_host_inst.wr(8'h43, 8'h00);
		ce_value[0] <= 16'h1111;
		tlr_host_inst.wr(8'h43, 8'h0f);
		rd0(8'hcd);
		rd0(8'hab);
		rd0(8'h11);
		rd0(8'h11);
	endtask

	// Read-back of status and count, repeats, null flag, mask
	task automatic t_readback();
		ce_value[0] <= 16'h2b2a;
		out_level[0] <= 1'b1;
		tlr_host_inst.wr(8'h43, 8'hc2);
		ce_value[0] <= 16'h3333;
		tlr_host_inst.wr(8'h43, 8'hc2);
		rd0(8'hf4);
		rd0(8'h2a);
		rd0(8'h2b);
		@(posedge mclk);
		ce_loaded[0] <= 1'b1;
		@(posedge mclk);
		ce_loaded[0] <= 1'b0;
		tlr_host_inst.wr(8'h43, 8'he2);
		rd0(8'hb4);
		rd0(8'h33);
		rd0(8'h33);
		tlr_host_inst.wr(8'h43, 8'hc4);
		ce_value[0] <= 16'h4455;
		rd0(8'h55);
		rd0(8'h44);
	endtask

	// Two counters latched before either is read
	task automatic t_multi();
		tlr_host_inst.wr(8'h43, 8'h74);
		ce_value <= {16'h0000, 16'h1c1d, 16'h0a0b};
		tlr_host_inst.wr(8'h43, 8'h00);
		tlr_host_inst.wr(8'h43, 8'h40);
		ce_value <= {16'h0000, 16'heeee, 16'hffff};
		rdc(8'h41, 8'h1d);
		rdc(8'h41, 8'h1c);
		rd0(8'h0b);
		rd0(8'h0a);
		rd0(8'hff);
	endtask

	// Reset in mid-run, then setup and null flag
	task automatic t_reset();
		rstn <= 1'b0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		chk(16'(byte_access_size[0]), 16'h0);
		tlr_host_inst.wr(8'h43, 8'he2);
		rd0(8'hc0);
		tlr_host_inst.wr(8'h40, 8'h99);
		repeat (2) @(posedge mclk);
		chk(init_count[0], 16'h0000);
		chk(16'(ctw_n), 16'h0002);
	endtask

	// Count setup pulses of counter 0
	always @(posedge mclk) begin
		if (ctrl_written[0]) begin
			cw_n++;
		end
		if (count_written[0]) begin
			ctw_n++;
		end
	end

	// Timeout guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			results();
		end
	end

	// Main sequence
	initial begin
		error_cnt = 0;
		n_tests = 0;
		cyc = 0;
		cw_n = 0;
		ctw_n = 0;
		rstn = 1'b0;
		ce_value = '0;
		out_level = 3'h0;
		ce_loaded = 3'h0;
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		t_program();
		t_latch();
		t_readback();
		t_multi();
		t_reset();
		results();
	end
endmodule
`default_nettype wire
